// ---- src/sch_device.sv ----
// Device end: command FIFO and the command interpreter
`timescale 1ns/1ps
`include "sch_cfg.svh"

// Flip-flop FIFO with registered ready
module sch_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

    // Storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers, count and registered ready
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            in_ready   <= 1'b0;
        end else begin
            if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)  rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            count_reg <= count_next;
            in_ready  <= (count_next < (AW+1)'(DEPTH));
        end
    end
endmodule : sch_fifo

// Contract
// R1: Host read request carries register id only
// R2: Read answer echoes id, then register data
// R3: Unknown register id returns an error code
// R4: Answer: zero, opcode, id, zero, little-endian data
// R5: Write carries id then data; echoed back
// R6: Save copies all registers to non-volatile store
// R7: Commands during save answered after it ends
// R8: Factory restore answers first, then defaults, reset
// R9: Reset answers first, then resets
// R10: Reset reloads saved values, else factory defaults
// R11: Firmware update only from serial port 1
// R12: Host keeps serial port 1 reachable
// R13: Prompt entry accepted on either serial port
// R14: Pause stops all periodic output on that port
// R15: Pause leaves output configuration registers unchanged
// R16: Pause parameter 0 pauses, 1 resumes
// R17: Poll 1 to 3 emits one packet
// R18: Rate zero: no periodic packets, poll works
// R19: Frames have fixed header, params, check trailer
// R20: Check is XOR; parameterless commands echoed
module sch_device #(
    parameter int          NREG        = 16,
    parameter int          FIFO_DEPTH  = 8,
    parameter int unsigned SAVE_CYCLES = `SCH_SAVE_CYCLES
) (
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    sch_link_if.dev     lnk,
    output logic        boot_mode,
    output logic [2:0]  prompt_mode,
    output logic [2:0]  async_paused,
    output logic [2:0]  periodic_en,
    output logic        poll_pulse,
    output logic [1:0]  poll_sel,
    output logic        soft_reset_pulse,
    output logic        save_busy
);
    localparam logic [7:0] NREG8 = 8'(NREG);

    sch_pkg::sch_dev_state_t state_reg;
    sch_pkg::sch_post_t      post_reg;
    logic [31:0] regs_reg   [NREG];
    logic [31:0] nv_reg     [NREG];
    logic        nv_valid_reg;
    logic [7:0]  buf_reg    [9];
    logic [7:0]  rbuf_reg   [8];
    logic [3:0]  cnt_reg;
    logic [3:0]  len_reg;
    logic [7:0]  chk_reg;
    logic [1:0]  port_reg;
    logic [31:0] save_cnt_reg;
    logic [7:0]  rsp_data_reg;
    logic        rsp_valid_reg;
    logic [9:0]  fifo_data;
    logic        fifo_valid;
    logic        fifo_pop;
    logic        id_ok;
    logic [7:0]  op;
    logic [7:0]  prm;
    logic [31:0] wdata;
    logic [31:0] rdata;

    sch_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_data   ({lnk.cmd_port, lnk.cmd_data}),
        .in_valid  (lnk.cmd_valid),
        .in_ready  (lnk.cmd_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    assign fifo_pop     = (state_reg == sch_pkg::DEV_RX);
    assign lnk.rsp_data  = rsp_data_reg;
    assign lnk.rsp_valid = rsp_valid_reg;
    assign op    = buf_reg[0];
    assign prm   = buf_reg[1];
    assign id_ok = (prm < NREG8);
    assign wdata = {buf_reg[7], buf_reg[6], buf_reg[5], buf_reg[4]};
    assign rdata = id_ok ? regs_reg[prm[$clog2(NREG)-1:0]] : 32'h0;

    // Sequencer; starts in POST so power-up loads registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg     <= sch_pkg::DEV_POST;
            post_reg      <= sch_pkg::POST_RELOAD;
            cnt_reg       <= 4'h0;
            len_reg       <= 4'h0;
            chk_reg       <= 8'h00;
            port_reg      <= 2'h0;
            rsp_data_reg  <= 8'h00;
            rsp_valid_reg <= 1'b0;
            for (int i = 0; i < 9; i++) buf_reg[i] <= 8'h00;
            for (int i = 0; i < 8; i++) rbuf_reg[i] <= 8'h00;
        end else begin
            unique case (state_reg)
                sch_pkg::DEV_RX: begin
                    if (fifo_valid) begin
                        buf_reg[cnt_reg] <= fifo_data[7:0];
                        port_reg <= fifo_data[9:8];
                        chk_reg  <= chk_reg ^ fifo_data[7:0];   // [R20]
                        // Frame length follows from the first byte [R19]
                        if (cnt_reg + 4'h1 == sch_pkg::sch_cmd_len(
                                (cnt_reg == 4'h0) ? fifo_data[7:0] : buf_reg[0])) begin
                            state_reg <= sch_pkg::DEV_EXEC;
                        end else begin
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                sch_pkg::DEV_EXEC: begin
                    // Held here while a save runs; the frame waits, not lost [R7]
                    if (save_cnt_reg == 32'h0) begin
                        rbuf_reg[0] <= 8'h00;                       // [R4]
                        rbuf_reg[1] <= op;
                        rbuf_reg[2] <= prm;
                        rbuf_reg[3] <= `SCH_ST_OK;
                        {rbuf_reg[7], rbuf_reg[6], rbuf_reg[5], rbuf_reg[4]} <=
                            (op == `SCH_OP_WRITE) ? wdata : rdata;  // [R2] [R5]
                        len_reg  <= `SCH_RSP_LEN_SHORT;
                        post_reg <= sch_pkg::POST_NONE;
                        if (chk_reg != 8'h00) begin
                            rbuf_reg[3] <= `SCH_ERR_CHKSUM;
                        end else begin
                            unique case (op)
                                `SCH_OP_READ, `SCH_OP_WRITE: begin
                                    if (id_ok) len_reg <= `SCH_RSP_LEN_DATA;  // [R4]
                                    else rbuf_reg[3] <= `SCH_ERR_BAD_ID;      // [R3]
                                end
                                `SCH_OP_RESTORE: post_reg <= sch_pkg::POST_RESTORE; // [R8]
                                `SCH_OP_RESET:   post_reg <= sch_pkg::POST_RELOAD;  // [R9]
                                `SCH_OP_FWU: begin
                                    if (port_reg != `SCH_PORT_SER1)
                                        rbuf_reg[3] <= `SCH_ERR_PARAM;        // [R11]
                                end
                                `SCH_OP_PROMPT: begin
                                    if (port_reg == `SCH_PORT_SPI)
                                        rbuf_reg[3] <= `SCH_ERR_PARAM;        // [R13]
                                end
                                `SCH_OP_PAUSE: begin
                                    if (prm > 8'h01) rbuf_reg[3] <= `SCH_ERR_PARAM; // [R16]
                                end
                                `SCH_OP_POLL: begin
                                    if (prm == 8'h00 || prm > 8'h03)
                                        rbuf_reg[3] <= `SCH_ERR_PARAM;        // [R17]
                                end
                                `SCH_OP_SAVE: ;
                                default: rbuf_reg[3] <= `SCH_ERR_BAD_OP;
                            endcase
                        end
                        cnt_reg   <= 4'h0;
                        state_reg <= sch_pkg::DEV_TX;
                    end
                end
                sch_pkg::DEV_TX: begin
                    // Answer goes out in full before any reset action [R8] [R9]
                    if (!rsp_valid_reg) begin
                        rsp_data_reg  <= rbuf_reg[cnt_reg[2:0]];
                        rsp_valid_reg <= 1'b1;
                    end else if (lnk.rsp_ready) begin
                        rsp_valid_reg <= 1'b0;
                        if (cnt_reg + 4'h1 == len_reg) state_reg <= sch_pkg::DEV_POST;
                        else cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                sch_pkg::DEV_POST: begin
                    post_reg  <= sch_pkg::POST_NONE;
                    cnt_reg   <= 4'h0;
                    chk_reg   <= 8'h00;
                    state_reg <= sch_pkg::DEV_RX;
                end
            endcase
        end
    end

    // Register set: written by the write command, reloaded by resets
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NREG; i++) regs_reg[i] <= `SCH_REG_DEFAULT;
        end else if (state_reg == sch_pkg::DEV_EXEC && save_cnt_reg == 32'h0 &&
                     chk_reg == 8'h00 && op == `SCH_OP_WRITE && id_ok) begin
            regs_reg[prm[$clog2(NREG)-1:0]] <= wdata;                         // [R5]
        end else if (state_reg == sch_pkg::DEV_POST) begin
            for (int i = 0; i < NREG; i++) begin
                if (post_reg == sch_pkg::POST_RESTORE)
                    regs_reg[i] <= `SCH_REG_DEFAULT;                          // [R8]
                else if (post_reg == sch_pkg::POST_RELOAD)
                    regs_reg[i] <= nv_valid_reg ? nv_reg[i] : `SCH_REG_DEFAULT; // [R10]
            end
        end
    end

    // Saved image; survives the reset command, not factory restore
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NREG; i++) nv_reg[i] <= `SCH_REG_DEFAULT;
            nv_valid_reg <= 1'b0;
            save_cnt_reg <= 32'h0;
        end else begin
            if (save_cnt_reg != 32'h0) save_cnt_reg <= save_cnt_reg - 32'h1;   // [R7]
            if (state_reg == sch_pkg::DEV_EXEC && save_cnt_reg == 32'h0 &&
                chk_reg == 8'h00 && op == `SCH_OP_SAVE) begin
                for (int i = 0; i < NREG; i++) nv_reg[i] <= regs_reg[i];      // [R6]
                nv_valid_reg <= 1'b1;
                save_cnt_reg <= SAVE_CYCLES;
            end
            // Factory restore forgets the saved image as well
            if (state_reg == sch_pkg::DEV_POST && post_reg == sch_pkg::POST_RESTORE)
                nv_valid_reg <= 1'b0;
        end
    end

    // Mode and output flags, clean frames only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            boot_mode        <= 1'b0;
            prompt_mode      <= 3'h0;
            async_paused     <= 3'h0;
            poll_pulse       <= 1'b0;
            poll_sel         <= 2'h0;
            soft_reset_pulse <= 1'b0;
        end else begin
            poll_pulse       <= 1'b0;
            soft_reset_pulse <= 1'b0;
            if (state_reg == sch_pkg::DEV_EXEC && save_cnt_reg == 32'h0 && chk_reg == 8'h00) begin
                if (op == `SCH_OP_FWU && port_reg == `SCH_PORT_SER1)
                    boot_mode <= 1'b1;                                        // [R11]
                if (op == `SCH_OP_PROMPT && port_reg != `SCH_PORT_SPI)
                    prompt_mode[port_reg] <= 1'b1;                            // [R13]
                // Only the receiving port's flag moves; config regs untouched [R14] [R15]
                if (op == `SCH_OP_PAUSE && prm <= 8'h01)
                    async_paused[port_reg] <= ~prm[0];                        // [R16]
                if (op == `SCH_OP_POLL && prm != 8'h00 && prm <= 8'h03) begin
                    poll_pulse <= 1'b1;                                       // [R17] [R18]
                    poll_sel   <= prm[1:0];
                end
            end
            // Reset clears session modes after the answer
            if (state_reg == sch_pkg::DEV_POST && post_reg != sch_pkg::POST_NONE) begin
                soft_reset_pulse <= 1'b1;
                prompt_mode      <= 3'h0;
                async_paused     <= 3'h0;
            end
        end
    end

    // Periodic streams need a nonzero rate
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            periodic_en <= 3'h0;
            save_busy   <= 1'b0;
        end else begin
            for (int k = 0; k < 3; k++)
                periodic_en[k] <= |regs_reg[int'(`SCH_ID_BIN_BASE) + k][`SCH_RATE_MSB:0]; // [R18]
            save_busy <= (save_cnt_reg > 32'h1);
        end
    end
endmodule : sch_device

// ---- src/sch_cfg.svh ----
// Constants for the system command handler: opcodes, codes, ids, timing
`ifndef SCH_CFG_SVH
`define SCH_CFG_SVH
`define SCH_OP_READ     8'h01
`define SCH_OP_WRITE    8'h02
`define SCH_OP_SAVE     8'h03
`define SCH_OP_RESTORE  8'h04
`define SCH_OP_RESET    8'h06
`define SCH_OP_FWU      8'h07
`define SCH_OP_PROMPT   8'h08
`define SCH_OP_PAUSE    8'h09
`define SCH_OP_POLL     8'h0a
`define SCH_ST_OK       8'h00
`define SCH_ERR_BAD_ID  8'h0b
`define SCH_ERR_PARAM   8'h0c
`define SCH_ERR_CHKSUM  8'h0d
`define SCH_ERR_BAD_OP  8'h0e
`define SCH_PORT_SPI    2'h0
`define SCH_PORT_SER1   2'h1
`define SCH_PORT_SER2   2'h2
`define SCH_ID_BIN_BASE 8'h0d
`define SCH_RATE_MSB    15
`define SCH_REG_DEFAULT 32'h0000_0000
`define SCH_CMD_LEN_SHORT 4'h5
`define SCH_CMD_LEN_WRITE 4'h9
`define SCH_RSP_LEN_SHORT 4'h4
`define SCH_RSP_LEN_DATA  4'h8
`define SCH_SAVE_MS     500
`define SCH_CLK_KHZ     125000
`define SCH_SAVE_CYCLES (`SCH_SAVE_MS * `SCH_CLK_KHZ)
`endif

// ---- src/sch_pkg.sv ----
// Types and shared helpers of the system command handler
package sch_pkg;
    typedef enum logic [1:0] {DEV_RX, DEV_EXEC, DEV_TX, DEV_POST} sch_dev_state_t;
    typedef enum logic [1:0] {HST_IDLE, HST_TX, HST_RX} sch_hst_state_t;
    typedef enum logic [1:0] {POST_NONE, POST_RESTORE, POST_RELOAD} sch_post_t;

    // Command frame length including the trailing check byte
    function automatic logic [3:0] sch_cmd_len(input logic [7:0] op);
        sch_cmd_len = (op == 8'h02) ? 4'h9 : 4'h5;
    endfunction : sch_cmd_len

    // Answer length from its opcode and status byte
    function automatic logic [3:0] sch_rsp_len(input logic [7:0] op, input logic [7:0] st);
        sch_rsp_len = ((op == 8'h01 || op == 8'h02) && st == 8'h00) ? 4'h8 : 4'h4;
    endfunction : sch_rsp_len
endpackage : sch_pkg

// ---- src/sch_link_if.sv ----
// Byte link between host end and device end, one stream each way
`timescale 1ns/1ps
interface sch_link_if;
    logic [7:0] cmd_data;
    logic [1:0] cmd_port;
    logic       cmd_valid;
    logic       cmd_ready;
    logic [7:0] rsp_data;
    logic       rsp_valid;
    logic       rsp_ready;
    modport dev  (input cmd_data, cmd_port, cmd_valid, rsp_ready,
                  output cmd_ready, rsp_data, rsp_valid);
    modport host (output cmd_data, cmd_port, cmd_valid, rsp_ready,
                  input cmd_ready, rsp_data, rsp_valid);
endinterface : sch_link_if

// ---- src/sch_host.sv ----
// Host end: frames requests, collects answers
`timescale 1ns/1ps
`include "sch_cfg.svh"
module sch_host (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    sch_link_if.host         lnk,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [7:0]  req_op,
    input  wire logic [7:0]  req_id,
    input  wire logic [31:0] req_data,
    input  wire logic [1:0]  req_port,
    output logic             ans_valid,
    output logic [7:0]       ans_op,
    output logic [7:0]       ans_id,
    output logic [7:0]       ans_status,
    output logic [31:0]      ans_data
);
    sch_pkg::sch_hst_state_t state_reg;
    logic [7:0] tbuf_reg [8];
    logic [7:0] rbuf_reg [8];
    logic [3:0] cnt_reg;
    logic [3:0] len_reg;
    logic [7:0] chk_reg;
    logic [7:0] cmd_data_reg;
    logic [1:0] cmd_port_reg;
    logic       cmd_valid_reg;
    logic       rsp_ready_reg;
    logic [3:0] rlen;

    assign lnk.cmd_data  = cmd_data_reg;
    assign lnk.cmd_port  = cmd_port_reg;
    assign lnk.cmd_valid = cmd_valid_reg;
    assign lnk.rsp_ready = rsp_ready_reg;
    assign rlen = (cnt_reg >= 4'h3) ? sch_pkg::sch_rsp_len(rbuf_reg[1],
                  (cnt_reg == 4'h3) ? lnk.rsp_data : rbuf_reg[3]) : 4'h8;

    // Request framing, byte send with back-pressure, answer collection
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg     <= sch_pkg::HST_IDLE;
            req_ready     <= 1'b0;
            cnt_reg       <= 4'h0;
            len_reg       <= 4'h0;
            chk_reg       <= 8'h00;
            cmd_data_reg  <= 8'h00;
            cmd_port_reg  <= 2'h0;
            cmd_valid_reg <= 1'b0;
            rsp_ready_reg <= 1'b0;
            ans_valid     <= 1'b0;
            ans_op        <= 8'h00;
            ans_id        <= 8'h00;
            ans_status    <= 8'h00;
            ans_data      <= 32'h0;
            for (int i = 0; i < 8; i++) tbuf_reg[i] <= 8'h00;
            for (int i = 0; i < 8; i++) rbuf_reg[i] <= 8'h00;
        end else begin
            ans_valid <= 1'b0;
            unique case (state_reg)
                sch_pkg::HST_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready   <= 1'b0;
                        // Opcode first, then the id or the single parameter [R1] [R16]
                        tbuf_reg[0] <= req_op;
                        tbuf_reg[1] <= req_id;
                        tbuf_reg[2] <= 8'h00;
                        tbuf_reg[3] <= 8'h00;
                        {tbuf_reg[7], tbuf_reg[6], tbuf_reg[5], tbuf_reg[4]} <= req_data; // [R5]
                        // Port 1 stays selectable for firmware update [R12]
                        cmd_port_reg <= req_port;
                        len_reg      <= sch_pkg::sch_cmd_len(req_op);              // [R19]
                        cnt_reg      <= 4'h0;
                        chk_reg      <= 8'h00;
                        state_reg    <= sch_pkg::HST_TX;
                    end
                end
                sch_pkg::HST_TX: begin
                    if (!cmd_valid_reg) begin
                        // Last byte of the frame is the running XOR [R20]
                        cmd_data_reg  <= (cnt_reg + 4'h1 == len_reg) ? chk_reg
                                                                     : tbuf_reg[cnt_reg[2:0]];
                        chk_reg       <= chk_reg ^ tbuf_reg[cnt_reg[2:0]];
                        cmd_valid_reg <= 1'b1;
                    end else if (lnk.cmd_ready) begin
                        cmd_valid_reg <= 1'b0;
                        if (cnt_reg + 4'h1 == len_reg) begin
                            cnt_reg       <= 4'h0;
                            rsp_ready_reg <= 1'b1;
                            state_reg     <= sch_pkg::HST_RX;
                        end else begin
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                sch_pkg::HST_RX: begin
                    if (lnk.rsp_valid && rsp_ready_reg) begin
                        rbuf_reg[cnt_reg[2:0]] <= lnk.rsp_data;
                        if (cnt_reg + 4'h1 == rlen) begin
                            // Data arrives least significant byte first
                            ans_valid     <= 1'b1;
                            ans_op        <= rbuf_reg[1];
                            ans_id        <= rbuf_reg[2];
                            ans_status    <= (cnt_reg == 4'h3) ? lnk.rsp_data : rbuf_reg[3];
                            ans_data      <= (cnt_reg == 4'h7) ? {lnk.rsp_data, rbuf_reg[6],
                                              rbuf_reg[5], rbuf_reg[4]} : 32'h0;
                            rsp_ready_reg <= 1'b0;
                            state_reg     <= sch_pkg::HST_IDLE;
                        end else begin
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                default: state_reg <= sch_pkg::HST_IDLE;
            endcase
        end
    end
endmodule : sch_host

// ---- testbench/sch_link_assertions.sv ----
// Link checker: framing and answer layout
`timescale 1ns/1ps
module sch_link_checker (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic [7:0] cmd_data,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [7:0] rsp_data,
    input wire logic       rsp_valid,
    input wire logic       rsp_ready
);
    logic [3:0] cmd_idx;
    logic [3:0] rsp_idx;
    logic [7:0] op_reg;
    logic [7:0] id_reg;
    logic       frame_end;
    // Last byte of a frame; writes are longer
    assign frame_end = cmd_valid && cmd_ready && cmd_idx == (op_reg == 8'h02 ? 4'h8 : 4'h4);
    // Byte positions; each stream restarts the other
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            {cmd_idx, rsp_idx, op_reg, id_reg} <= '0;
        end else begin
            if (cmd_valid && cmd_ready) begin
                cmd_idx <= cmd_idx + 4'h1;
                rsp_idx <= 4'h0;
                if (cmd_idx == 4'h0) op_reg <= cmd_data;
                if (cmd_idx == 4'h1) id_reg <= cmd_data;
            end
            if (rsp_valid && rsp_ready) begin
                rsp_idx <= rsp_idx + 4'h1;
                cmd_idx <= 4'h0;
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_gap;
        ##1 !rsp_valid;
    endsequence
    chk_cmd_holds: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
        else $error("cmd byte changed");
    chk_rsp_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("rsp byte changed");
    chk_rsp_pause: assert property (rsp_valid && rsp_ready |-> s_gap)
        else $error("rsp valid not dropped");
    chk_lead_zero: assert property (rsp_valid && rsp_idx == 4'h0 |-> rsp_data == 8'h00)
        else $error("no lead zero");
    chk_echo_op: assert property (rsp_valid && rsp_idx == 4'h1 |-> rsp_data == op_reg)
        else $error("op echo wrong");
    chk_echo_id: assert property (rsp_valid && rsp_idx == 4'h2 |-> rsp_data == id_reg)
        else $error("id echo wrong");
    chk_rsp_len: assert property (rsp_valid |-> rsp_idx < 4'h8)
        else $error("answer too long");
    chk_frame_ans: assert property (frame_end |-> ##[1:150] rsp_valid)
        else $error("frame unanswered");
    chk_cmd_drain: assert property (cmd_valid |-> ##[0:150] cmd_ready)
        else $error("cmd byte stuck");
endmodule : sch_link_checker

// ---- testbench/testbench.sv ----
// Bench: host and device ends joined by the link
`timescale 1ns/1ps
module testbench;
    logic        clk_sys, reset_n, req_valid, req_ready, ans_valid, boot_mode, poll_pulse;
    logic        soft_reset_pulse, save_busy, srst_seen;
    logic [7:0]  req_op, req_id, ans_op, ans_id, ans_status;
    logic [31:0] req_data, ans_data;
    logic [1:0]  req_port, poll_sel;
    logic [2:0]  prompt_mode, async_paused, periodic_en;
    int          failures, n_checks;
    localparam logic [31:0] Z = 32'h0;
    sch_link_if lnk ();
    // Short save keeps the run brief
    sch_device #(.SAVE_CYCLES(40)) sch_device_i (.clk_sys, .reset_n, .lnk(lnk.dev), .boot_mode,
        .prompt_mode, .async_paused, .periodic_en, .poll_pulse, .poll_sel, .soft_reset_pulse,
        .save_busy);
    sch_host sch_host_i (.clk_sys, .reset_n, .lnk(lnk.host), .req_valid, .req_ready, .req_op,
        .req_id, .req_data, .req_port, .ans_valid, .ans_op, .ans_id, .ans_status, .ans_data);
    sch_link_checker sch_link_checker_i (.clk_sys, .reset_n, .cmd_data(lnk.cmd_data),
        .cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready), .rsp_data(lnk.rsp_data),
        .rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready));
    always #4 clk_sys = ~clk_sys;
    // Latch pulse for a late check
    always @(posedge clk_sys) if (soft_reset_pulse === 1'b1) srst_seen <= 1'b1;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One request; answer judged in full
    task automatic xfer(input logic [7:0] op, id, input logic [31:0] d, input logic [1:0] p,
                        input logic [7:0] es, input logic [31:0] ed);
        while (req_ready !== 1'b1) @(negedge clk_sys);
        @(posedge clk_sys);
        #1 {req_valid, req_op, req_id, req_data, req_port} = {1'b1, op, id, d, p};
        @(posedge clk_sys);
        #1 req_valid = 1'b0;
        for (int n = 0; n < 3000 && ans_valid !== 1'b1; n++) @(negedge clk_sys);
        check(ans_valid, 1'b1);
        check({ans_op, ans_id, ans_status}, {op, id, es});
        check(ans_data, ed);
    endtask : xfer
    task automatic t_regs;
        xfer(8'h01, 8'h05, Z, 2'h0, 8'h00, Z);
        xfer(8'h02, 8'h05, 32'h2580, 2'h1, 8'h00, 32'h2580);
        xfer(8'h01, 8'h05, Z, 2'h0, 8'h00, 32'h2580);
        xfer(8'h01, 8'h10, Z, 2'h0, 8'h0b, Z);
        xfer(8'h02, 8'h1f, 32'h1, 2'h2, 8'h0b, Z);
        xfer(8'h0f, 8'h00, Z, 2'h0, 8'h0e, Z);
    endtask : t_regs
    // Write waits for save; reset reloads image
    task automatic t_save_reset;
        xfer(8'h03, 8'h00, Z, 2'h0, 8'h00, Z);
        check(save_busy, 1'b1);
        xfer(8'h02, 8'h05, 32'h1, 2'h0, 8'h00, 32'h1);
        check(save_busy, 1'b0);
        srst_seen = 1'b0;
        xfer(8'h06, 8'h00, Z, 2'h0, 8'h00, Z);
        repeat (20) @(negedge clk_sys);
        check(srst_seen, 1'b1);
        xfer(8'h01, 8'h05, Z, 2'h0, 8'h00, 32'h2580);
        xfer(8'h04, 8'h00, Z, 2'h0, 8'h00, Z);
        repeat (20) @(negedge clk_sys);
        xfer(8'h01, 8'h05, Z, 2'h0, 8'h00, Z);
    endtask : t_save_reset
    task automatic t_modes;
        xfer(8'h02, 8'h0d, 32'h10, 2'h0, 8'h00, 32'h10);
        check(periodic_en, 3'h1);
        xfer(8'h09, 8'h00, Z, 2'h1, 8'h00, Z);
        check({async_paused, periodic_en}, {3'h2, 3'h1});
        xfer(8'h09, 8'h01, Z, 2'h1, 8'h00, Z);
        check(async_paused, 3'h0);
        xfer(8'h09, 8'h02, Z, 2'h2, 8'h0c, Z);
        xfer(8'h08, 8'h00, Z, 2'h2, 8'h00, Z);
        xfer(8'h08, 8'h00, Z, 2'h0, 8'h0c, Z);
        check(prompt_mode, 3'h4);
        xfer(8'h02, 8'h0d, Z, 2'h0, 8'h00, Z);
        xfer(8'h0a, 8'h01, Z, 2'h0, 8'h00, Z);
        check({periodic_en, poll_sel}, {3'h0, 2'h1});
        xfer(8'h0a, 8'h03, Z, 2'h0, 8'h00, Z);
        xfer(8'h0a, 8'h04, Z, 2'h0, 8'h0c, Z);
        check(poll_sel, 2'h3);
        xfer(8'h07, 8'h00, Z, 2'h2, 8'h0c, Z);
        check(boot_mode, 1'b0);
        xfer(8'h07, 8'h00, Z, 2'h1, 8'h00, Z);
        check(boot_mode, 1'b1);
    endtask : t_modes
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    initial begin
        {clk_sys, reset_n, req_valid, srst_seen, req_op, req_id, req_data, req_port} = '0;
        repeat (16) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        t_regs();
        t_save_reset();
        t_modes();
        conclude();
    end
    // Watchdog well past expected run
    initial begin
        #400000;
        failures++;
        conclude();
    end
endmodule : testbench
